// ### shared/sio_pkg.sv
/*
  Constants for the clock-synchronous serial unit: register offsets, field
  positions, fixed read values, mode codes and the state encoding.
  Assumes a byte-addressed register port with 32-bit aligned words.
*/
package sio_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_OPERATE  = 8'h04;
  localparam logic [7:0] OFF_CTRL1    = 8'h08;
  localparam logic [7:0] OFF_CTRL2    = 8'h0C;
  localparam logic [7:0] OFF_DATA     = 8'h10;
  localparam logic [7:0] OFF_INT_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  // Status register: flag positions and fixed bits.
  localparam int         BIT_XFER     = 3;
  localparam int         BIT_SHIFT    = 2;
  localparam logic [7:0] STATUS_FIXED = 8'hF3;
  // Operate register: operate bit position and fixed bits.
  localparam int         BIT_OPERATE  = 6;
  localparam logic [7:0] OPER_FIXED   = 8'hBE;
  // First control register fields.
  localparam int         BIT_START    = 7;
  localparam int         BIT_INHIBIT  = 6;
  localparam int         POS_XMODE    = 4;
  localparam int         POS_CLKSEL   = 0;
  // Second control register: mode field position and fixed bits.
  localparam int         POS_OPMODE   = 2;
  localparam logic [7:0] CTRL2_FIXED  = 8'hF3;
  // Mode codes.
  localparam logic [1:0] OPMODE_SIO   = 2'h1;
  localparam logic [1:0] XMODE_TX     = 2'h0;
  localparam logic [1:0] XMODE_TXRX   = 2'h2;
  localparam logic [1:0] XMODE_RX     = 2'h3;
  localparam logic [2:0] CLKSEL_EXT   = 3'h7;
  // Interrupt status bits and the last bit count.
  localparam int         INT_EMPTY    = 0;
  localparam int         INT_FULL     = 1;
  localparam logic [2:0] LAST_BIT     = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_SHIFT = 3'b100
  } state_t;
endpackage

// ### hdl/sio_sync2.sv
/*
  Two-flop synchroniser for pins that come from outside the clock domain.
  Assumes the inputs change slowly against sys_clk and idle high; both
  stages reset high so that no false edge follows reset.
*/
`timescale 1ns/1ps
module sio_sync2 #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // The first stage is read by the second stage only.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_r <= '1;
      q_r    <= '1;
    end else if (ce) begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// ### hdl/sio_rate_gen.sv
/*
  Half-period tick generator for the internal serial clock, seven rates.
  Assumes run is low between transfers, which restarts the count.
*/
`timescale 1ns/1ps
module sio_rate_gen #(
  parameter int CNT_W = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] limit;

  generate
    if (CNT_W < 7) begin : g_bad_width
      $error("sio_rate_gen: CNT_W must be at least 7");
    end
  endgenerate

  // Half period is 2^(sel+1) cycles; the slowest code needs 7 bits.
  always_comb begin
    limit   = CNT_W'((9'h002 << sel) - 9'h001);
    tick    = run && (cnt_r == limit);
    cnt_nxt = (!run || tick) ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ### hdl/sio_unit.sv
/*
  Clock-synchronous 8-bit serial unit: register port, transfer control,
  internal or external serial clock, automatic wait and interrupt.
  Assumes a register master with one-cycle strobes and pins that are
  asynchronous to sys_clk; the serial clock pin is resolved outside.
*/
// The address-and-strobe port and the address map are this design's own decisions.
// Functional notes
// - Status shows a transfer flag and a shift flag, 1 while busy, 0 when done.
// - The clock select field in the first control register picks the clock.
// - Select code 111 shifts on the clock that the partner drives on the pin.
// - Other codes give one of seven internal rates driven out on the pin.
// - With an internal clock the pin is driven high as a transfer begins.
// - With an internal clock, if software lags on the buffer, the clock stops and shifting waits.
// - Transmit data moves on the leading edge.
// - Receive data is taken on the trailing edge.
// - The leading edge is the falling edge of the pin, whoever drives it.
// - The unit works only with the operating mode field at 01.
// - The trailing edge is the rising edge of the pin.
// - Transmit loads the buffer into the shifter, sends LSB first, flags empty.
// - Receive gathers eight bits LSB first, stores them and flags full.
`timescale 1ns/1ps
module sio_unit
  import sio_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          ce,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [31:0]   rdata,
  input  wire logic          sck_in,
  output logic               sck_out,
  output logic               sck_oe_n,
  output logic               sdo,
  input  wire logic          sdi,
  output logic               transfer_interrupt
);
  generate
    if (AW < 8) begin : g_bad_aw
      $error("sio_unit: AW must be at least 8");
    end
  endgenerate

  state_t      state_r, state_nxt;
  logic        unit_operate_bit_r, unit_operate_bit_nxt;
  logic        start_r, start_nxt;
  logic        inhibit_r, inhibit_nxt;
  logic [1:0]  xmode_r, xmode_nxt;
  logic [2:0]  clock_source_select_r, clock_source_select_nxt;
  logic [1:0]  operating_mode_field_r, operating_mode_field_nxt;
  logic [7:0]  data_buf_r, data_buf_nxt;
  logic        tx_loaded_r, tx_loaded_nxt;
  logic        rx_pending_r, rx_pending_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [2:0]  bit_cnt_r, bit_cnt_nxt;
  logic        sck_r, sck_nxt;
  logic        sdo_r, sdo_nxt;
  logic [1:0]  int_stat_r, int_stat_nxt;
  logic [1:0]  int_mask_r, int_mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        sck_prev_r;
  logic [1:0]  pins_s;
  logic        sck_s, sdi_s, tick;
  logic        enabled, internal, tx_mode, rx_mode, ready, fall_ev, rise_ev;
  logic        transfer_active_flag, shift_active_flag;
  logic [7:0]  status_rd;
  logic [1:0]  int_set;

  // Pin inputs cross into the sys_clk domain before any use.
  sio_sync2 #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ce      (ce),
    .d       ({sck_in, sdi}),
    .q       (pins_s)
  );
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // Internal rate only runs while bits are moving, so a wait stops the clock.
  sio_rate_gen #(.CNT_W(8)) u_rate (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ce      (ce),
    .run     (state_r == ST_SHIFT && internal),
    .sel     (clock_source_select_r),
    .tick    (tick)
  );

  // Decoded modes, edges and status.
  always_comb begin
    enabled  = unit_operate_bit_r && (operating_mode_field_r == OPMODE_SIO);
    internal = (clock_source_select_r != CLKSEL_EXT);
    tx_mode  = (xmode_r == XMODE_TX) || (xmode_r == XMODE_TXRX);
    rx_mode  = (xmode_r == XMODE_RX) || (xmode_r == XMODE_TXRX);
    // Internal waits for software; an external clock cannot be held.
    ready    = !internal || ((!tx_mode || tx_loaded_r) && (!rx_mode || !rx_pending_r));
    // Falling edge is leading, rising edge is trailing, for either source.
    fall_ev  = internal ? (tick && sck_r) : (sck_prev_r && !sck_s);
    rise_ev  = internal ? (tick && !sck_r) : (!sck_prev_r && sck_s);
    transfer_active_flag = (state_r != ST_IDLE);
    shift_active_flag    = (state_r == ST_SHIFT);
    status_rd = STATUS_FIXED;
    status_rd[BIT_XFER]  = transfer_active_flag;
    status_rd[BIT_SHIFT] = shift_active_flag;
  end

  // Next-state logic for registers, transfer sequencer and read port.
  always_comb begin
    state_nxt                = state_r;
    unit_operate_bit_nxt     = unit_operate_bit_r;
    start_nxt                = start_r;
    inhibit_nxt              = inhibit_r;
    xmode_nxt                = xmode_r;
    clock_source_select_nxt  = clock_source_select_r;
    operating_mode_field_nxt = operating_mode_field_r;
    data_buf_nxt             = data_buf_r;
    tx_loaded_nxt            = tx_loaded_r;
    rx_pending_nxt           = rx_pending_r;
    shift_nxt                = shift_r;
    bit_cnt_nxt              = bit_cnt_r;
    sck_nxt                  = sck_r;
    sdo_nxt                  = sdo_r;
    int_mask_nxt             = int_mask_r;
    int_set                  = 2'h0;
    rdata_nxt                = 32'h0000_0000;

    // Software writes; fixed bits of each register are never stored.
    if (wr) begin
      unique case (addr[7:0])
        OFF_OPERATE:  unit_operate_bit_nxt = wdata[BIT_OPERATE];
        OFF_CTRL1: begin
          inhibit_nxt             = wdata[BIT_INHIBIT];
          start_nxt               = wdata[BIT_START] && !wdata[BIT_INHIBIT];
          xmode_nxt               = wdata[POS_XMODE +: 2];
          clock_source_select_nxt = wdata[POS_CLKSEL +: 3];
        end
        OFF_CTRL2:    operating_mode_field_nxt = wdata[POS_OPMODE +: 2];
        OFF_DATA: begin
          data_buf_nxt  = wdata[7:0];
          tx_loaded_nxt = 1'b1;
        end
        OFF_INT_MASK: int_mask_nxt = wdata[1:0];
        default: ;
      endcase
    end

    // Reads answer in the next cycle; unmapped offsets read zero.
    if (rd) begin
      unique case (addr[7:0])
        OFF_STATUS:   rdata_nxt = {24'h000000, status_rd};
        OFF_OPERATE:  rdata_nxt = {24'h000000, OPER_FIXED | (8'(unit_operate_bit_r) << BIT_OPERATE)};
        OFF_CTRL1:    rdata_nxt = {24'h000000, start_r, inhibit_r, xmode_r, 1'b0,
                                   clock_source_select_r};
        OFF_CTRL2:    rdata_nxt = {24'h000000, CTRL2_FIXED |
                                   (8'(operating_mode_field_r) << POS_OPMODE)};
        OFF_DATA: begin
          rdata_nxt      = {24'h000000, data_buf_r};
          rx_pending_nxt = 1'b0;
        end
        OFF_INT_STAT: rdata_nxt = {30'h00000000, int_stat_r};
        OFF_INT_MASK: rdata_nxt = {30'h00000000, int_mask_r};
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end

    // Sequencer. Inhibit or leaving the mode aborts at once.
    if (!enabled || inhibit_nxt) begin
      state_nxt = ST_IDLE;
      start_nxt = 1'b0;
      sck_nxt   = 1'b1; // An abort mid-byte must not leave the pin parked low.
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_nxt) begin
            state_nxt = ST_WAIT;
            sck_nxt   = 1'b1;
          end
        end
        ST_WAIT: begin
          if (!start_r) begin
            state_nxt = ST_IDLE;
          end else if (ready) begin
            state_nxt   = ST_SHIFT;
            bit_cnt_nxt = 3'h0;
            if (tx_mode) begin
              shift_nxt     = data_buf_r;
              tx_loaded_nxt = 1'b0;
              int_set[INT_EMPTY] = 1'b1;
            end
          end
        end
        ST_SHIFT: begin
          if (fall_ev) begin
            sck_nxt = 1'b0;
            sdo_nxt = shift_r[0];
          end else if (rise_ev) begin
            sck_nxt     = 1'b1;
            shift_nxt   = {sdi_s, shift_r[7:1]};
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == LAST_BIT) begin
              if (rx_mode) begin
                data_buf_nxt      = {sdi_s, shift_r[7:1]};
                rx_pending_nxt    = 1'b1;
                int_set[INT_FULL] = 1'b1;
              end
              // A cleared start lets the current byte finish, then stops.
              state_nxt = start_r ? ST_WAIT : ST_IDLE;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end

    // Sticky flags: write one to clear, a new event in the same cycle wins.
    int_stat_nxt = int_stat_r;
    if (wr && addr[7:0] == OFF_INT_STAT) begin
      int_stat_nxt = int_stat_r & ~wdata[1:0];
    end
    int_stat_nxt = int_stat_nxt | int_set;
  end

  // State registers; a low clock enable freezes everything.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r                <= ST_IDLE;
      unit_operate_bit_r     <= 1'b0;
      start_r                <= 1'b0;
      inhibit_r              <= 1'b0;
      xmode_r                <= XMODE_TX;
      clock_source_select_r  <= 3'h0;
      operating_mode_field_r <= 2'h0;
      data_buf_r             <= 8'h00;
      tx_loaded_r            <= 1'b0;
      rx_pending_r           <= 1'b0;
      shift_r                <= 8'h00;
      bit_cnt_r              <= 3'h0;
      sck_r                  <= 1'b1;
      sdo_r                  <= 1'b1;
      int_stat_r             <= 2'h0;
      int_mask_r             <= 2'h0;
      rdata_r                <= 32'h0000_0000;
      sck_prev_r             <= 1'b1;
    end else if (ce) begin
      state_r                <= state_nxt;
      unit_operate_bit_r     <= unit_operate_bit_nxt;
      start_r                <= start_nxt;
      inhibit_r              <= inhibit_nxt;
      xmode_r                <= xmode_nxt;
      clock_source_select_r  <= clock_source_select_nxt;
      operating_mode_field_r <= operating_mode_field_nxt;
      data_buf_r             <= data_buf_nxt;
      tx_loaded_r            <= tx_loaded_nxt;
      rx_pending_r           <= rx_pending_nxt;
      shift_r                <= shift_nxt;
      bit_cnt_r              <= bit_cnt_nxt;
      sck_r                  <= sck_nxt;
      sdo_r                  <= sdo_nxt;
      int_stat_r             <= int_stat_nxt;
      int_mask_r             <= int_mask_nxt;
      rdata_r                <= rdata_nxt;
      sck_prev_r             <= sck_s;
    end
  end

  // Pin drive: the clock pin is driven only for an internal clock.
  assign sck_out  = sck_r;
  assign sck_oe_n = !(enabled && internal);
  assign sdo      = sdo_r;
  assign rdata    = rdata_r;
  assign transfer_interrupt = |(int_stat_r & int_mask_r);

  // Checks kept beside the logic they watch.
  property p_status_read;
    @(posedge sys_clk) disable iff (reset)
    (ce && rd && addr[7:0] == OFF_STATUS) |=> rdata[BIT_XFER] == $past(transfer_active_flag);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status flag misread");

  property p_shift_in_xfer;
    @(posedge sys_clk) disable iff (reset)
    shift_active_flag |-> transfer_active_flag;
  endproperty
  a_shift_in_xfer: assert property (p_shift_in_xfer) else $error("shift without transfer");

  property p_fixed_bits;
    @(posedge sys_clk) disable iff (reset)
    (ce && rd && addr[7:0] == OFF_STATUS) |=> rdata[7:4] == 4'hF && rdata[1:0] == 2'h3;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("status fixed bits wrong");

  property p_start_high;
    @(posedge sys_clk) disable iff (reset)
    (state_r == ST_WAIT && internal) |-> sck_out;
  endproperty
  a_start_high: assert property (p_start_high) else $error("clock not high at start");

  property p_wait_holds;
    @(posedge sys_clk) disable iff (reset)
    (ce && state_r == ST_WAIT && internal && !ready) |=> state_r != ST_SHIFT;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("shifted while waiting");

  property p_ext_no_wait;
    @(posedge sys_clk) disable iff (reset)
    (ce && state_r == ST_WAIT && !internal && start_r && enabled && !inhibit_nxt)
      |=> state_r == ST_SHIFT;
  endproperty
  a_ext_no_wait: assert property (p_ext_no_wait) else $error("external clock waited");

  property p_tx_on_fall;
    @(posedge sys_clk) disable iff (reset)
    (ce && state_r == ST_SHIFT && fall_ev && enabled && !inhibit_nxt)
      |=> sdo == $past(shift_r[0]) && !sck_out;
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall) else $error("transmit bit not on fall");

  property p_rx_on_rise;
    @(posedge sys_clk) disable iff (reset)
    (ce && state_r == ST_SHIFT && rise_ev && enabled && !inhibit_nxt)
      |=> shift_r[7] == $past(sdi_s) && sck_out;
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise) else $error("receive bit not on rise");

  property p_mode_gate;
    @(posedge sys_clk) disable iff (reset)
    (ce && operating_mode_field_r != OPMODE_SIO) |=> state_r == ST_IDLE;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("active outside serial mode");

  property p_rx_full;
    @(posedge sys_clk) disable iff (reset)
    (ce && state_r == ST_SHIFT && rise_ev && bit_cnt_r == LAST_BIT && rx_mode && enabled
      && !inhibit_nxt) |=> int_stat_r[INT_FULL] && data_buf_r[7] == $past(sdi_s);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive byte not stored");
endmodule

// ### test/sio_partner.sv
/*
  Model of the far serial device: resolves the clock wire, sends a byte
  on the data-in line and takes the data-out line, with its own clock.
  Assumes the unit drives the clock only while its enable is low.
*/
`timescale 1ns/1ps
module sio_partner (
  input  wire logic       sck_out,
  input  wire logic       sck_oe_n,
  input  wire logic       sdo,
  output logic            sck_wire,
  output logic            sdi,
  output logic [7:0]      rx_byte,
  output int              nbits
);
  logic       ext_drv;
  logic       ext_sck;
  logic [7:0] tx_byte;

  // The wire has a pull-up, so it idles high when nobody drives it.
  assign sck_wire = !sck_oe_n ? sck_out : (ext_drv ? ext_sck : 1'b1);

  initial begin
    ext_drv = 1'b0;
    ext_sck = 1'b1;
    tx_byte = 8'h00;
    rx_byte = 8'h00;
    nbits   = 0;
    sdi     = 1'b1;
  end

  // Next bit goes out on the falling edge, LSB first.
  always @(negedge sck_wire) begin
    if (nbits < 8) begin
      sdi <= tx_byte[nbits[2:0]];
    end
  end

  // The unit answers an outside clock late by its synchroniser, so the bit
  // is taken a little after the rising edge then; after the eighth bit, data-in turns to the inverse.
  always @(posedge sck_wire) begin
    if (ext_drv) begin
      #16;
    end
    rx_byte <= {sdo, rx_byte[7:1]};
    if (nbits == 7) begin
      sdi <= #30 ~tx_byte[7];
    end
    nbits <= nbits + 1;
  end

  // Eight clock periods of 48 ns, high outside the frame.
  task automatic ext_frame();
    #3 ext_drv = 1'b1;
    repeat (8) begin
      #24 ext_sck = 1'b0;
      #24 ext_sck = 1'b1;
    end
    #24 ext_drv = 1'b0;
  endtask

  task automatic load(input logic [7:0] b);
    tx_byte = b;
    nbits   = 0;
  endtask
endmodule

// ### test/tb_sio_unit.sv
/*
  Self-checking bench for the serial unit: registers, seven internal
  rates, automatic wait, receive, external clock and interrupt.
  Assumes the far-side model in sio_partner and a 200 MHz clock.
*/
`timescale 1ns/1ps
module tb_sio_unit;
  import sio_pkg::*;
  localparam logic [31:0] INHIBIT = 32'h0000_0001 << BIT_INHIBIT;
  logic        sys_clk;
  logic        reset;
  logic        ce;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sck_wire;
  logic        sck_out;
  logic        sck_oe_n;
  logic        sdo;
  logic        sdi;
  logic        irq;
  logic [7:0]  p_rx;
  int          p_bits;
  int          fail_count;
  int          checked;
  logic [31:0] d;

  sio_unit i_sio_unit (.sys_clk(sys_clk), .reset(reset), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sck_in(sck_wire), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .sdo(sdo), .sdi(sdi), .transfer_interrupt(irq));
  sio_partner i_sio_partner (.sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo),
    .sck_wire(sck_wire), .sdi(sdi), .rx_byte(p_rx), .nbits(p_bits));

  // Free-running 5 ns clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_bit(input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // A wait that ran out is a mismatch and ends the run.
  task automatic hang();
    chk_bit(1'b1, 1'b0);
    wrap_up();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_sck(input logic v);
    int i;
    for (i = 0; i < 300 && sck_out !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (sck_out !== v) hang();
  endtask

  task automatic chk_stopped(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 chk_bit(1'b1, sck_wire);
    end
  endtask

  function automatic logic [31:0] cr1(input logic [1:0] xm, input logic [2:0] sel);
    return (32'h1 << BIT_START) | (32'(xm) << POS_XMODE) | 32'(sel);
  endfunction

  task automatic t_regs();
    chk_bit(1'b0, irq);
    rd_reg(OFF_STATUS, d);
    chk_word(32'h0000_00F3, d);
    wr_reg(OFF_STATUS, 32'hFFFF_FFFF);
    rd_reg(OFF_STATUS, d);
    chk_word(32'h0000_00F3, d);
    rd_reg(OFF_OPERATE, d);
    chk_word(32'h0000_00BE, d);
    wr_reg(OFF_OPERATE, 32'hFFFF_FFFF);
    rd_reg(OFF_OPERATE, d);
    chk_word(32'h0000_00FE, d);
    rd_reg(8'h1C, d);
    chk_word(32'h0000_0000, d);
    // A low clock enable must drop the write, so the mode field stays clear.
    @(posedge sys_clk);
    ce <= 1'b0;
    wr_reg(OFF_CTRL2, 32'h0000_0004);
    ce <= 1'b1;
    rd_reg(OFF_CTRL2, d);
    chk_word(32'(CTRL2_FIXED), d);
  endtask

  // A start outside the serial mode must not move the clock.
  task automatic t_mode();
    // Clear the bit count so an edge seen as the wire settles is not counted.
    i_sio_partner.load(8'h00);
    wr_reg(OFF_CTRL2, 32'h0000_0008);
    wr_reg(OFF_DATA, 32'h0000_0055);
    wr_reg(OFF_CTRL1, cr1(XMODE_TX, 3'h0));
    repeat (20) @(posedge sys_clk);
    rd_reg(OFF_STATUS, d);
    chk_word(32'h0000_00F3, d);
    chk_word(32'h0000_0000, 32'(p_bits));
    wr_reg(OFF_CTRL1, INHIBIT);
    wr_reg(OFF_CTRL2, 32'(OPMODE_SIO) << POS_OPMODE);
  endtask

  task automatic t_tx_rates();
    int s;
    int n;
    logic [7:0] b;
    wr_reg(OFF_INT_MASK, 32'h0000_0003);
    for (s = 0; s < 7; s++) begin
      b = 8'hA5 ^ 8'(s * 17);
      wr_reg(OFF_DATA, 32'(b));
      i_sio_partner.load(8'h00);
      wr_reg(OFF_CTRL1, cr1(XMODE_TX, 3'(s)));
      @(posedge sys_clk);
      #1 chk_bit(1'b1, sck_out);
      chk_bit(1'b0, sck_oe_n);
      wait_sck(1'b0);
      rd_reg(OFF_STATUS, d);
      chk_word(32'h0000_00FF, d);
      chk_bit(1'b1, irq);
      wait_sck(1'b0);
      wait_sck(1'b1);
      n = 0;
      while (sck_out === 1'b1 && n < 300) begin
        n++;
        @(posedge sys_clk);
        #1;
      end
      chk_word(32'h1 << (s + 1), 32'(n));
      for (n = 0; n < 3000 && p_bits < 8; n++) @(posedge sys_clk);
      if (p_bits < 8) hang();
      chk_stopped(40);
      chk_word(32'(b), 32'(p_rx));
      rd_reg(OFF_STATUS, d);
      chk_word(32'h0000_00FB, d);
      wr_reg(OFF_INT_STAT, 32'h0000_0001);
      #1 chk_bit(1'b0, irq);
      wr_reg(OFF_CTRL1, INHIBIT);
      rd_reg(OFF_STATUS, d);
      chk_word(32'h0000_00F3, d);
    end
  endtask

  // Receive with the interrupt masked first, then unmasked.
  task automatic t_rx();
    int n;
    wr_reg(OFF_INT_MASK, 32'h0000_0000);
    i_sio_partner.load(8'h5A);
    wr_reg(OFF_CTRL1, cr1(XMODE_RX, 3'h1));
    d = 32'h0000_0000;
    for (n = 0; n < 200 && d[INT_FULL] !== 1'b1; n++) rd_reg(OFF_INT_STAT, d);
    if (d[INT_FULL] !== 1'b1) hang();
    chk_bit(1'b0, irq);
    chk_stopped(40);
    i_sio_partner.load(8'hC3);
    wr_reg(OFF_INT_STAT, 32'h0000_0002);
    wr_reg(OFF_INT_MASK, 32'h0000_0002);
    rd_reg(OFF_DATA, d);
    chk_word(32'h0000_005A, d);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge sys_clk);
    chk_bit(1'b1, irq);
    rd_reg(OFF_DATA, d);
    chk_word(32'h0000_00C3, d);
    wr_reg(OFF_CTRL1, INHIBIT);
    wr_reg(OFF_INT_STAT, 32'h0000_0002);
    #1 chk_bit(1'b0, irq);
  endtask

  // The partner clocks one byte each way; the unit must not drive the pin.
  task automatic t_ext();
    wr_reg(OFF_DATA, 32'h0000_0096);
    i_sio_partner.load(8'h69);
    wr_reg(OFF_CTRL1, cr1(XMODE_TXRX, CLKSEL_EXT));
    repeat (4) @(posedge sys_clk);
    #1 chk_bit(1'b1, sck_oe_n);
    i_sio_partner.ext_frame();
    repeat (10) @(posedge sys_clk);
    chk_word(32'h0000_0096, 32'(p_rx));
    rd_reg(OFF_DATA, d);
    chk_word(32'h0000_0069, d);
    wr_reg(OFF_CTRL1, INHIBIT);
  endtask

  // A cleared start finishes the byte and stops; then a reset in mid-byte.
  task automatic t_stop_reset();
    int n;
    wr_reg(OFF_INT_STAT, 32'h0000_0003);
    wr_reg(OFF_INT_MASK, 32'h0000_0001);
    wr_reg(OFF_DATA, 32'h0000_003C);
    i_sio_partner.load(8'h00);
    wr_reg(OFF_CTRL1, cr1(XMODE_TX, 3'h0));
    wait_sck(1'b0);
    wr_reg(OFF_CTRL1, 32'h0000_0000);
    for (n = 0; n < 300 && p_bits < 8; n++) @(posedge sys_clk);
    if (p_bits < 8) hang();
    repeat (4) @(posedge sys_clk);
    rd_reg(OFF_STATUS, d);
    chk_word(32'h0000_00F3, d);
    chk_word(32'h0000_003C, 32'(p_rx));
    wr_reg(OFF_DATA, 32'h0000_003C);
    wr_reg(OFF_CTRL1, cr1(XMODE_TX, 3'h0));
    wait_sck(1'b0);
    @(posedge sys_clk);
    reset <= 1'b1;
    @(posedge sys_clk);
    #1 chk_bit(1'b1, sck_out);
    chk_bit(1'b1, sdo);
    chk_bit(1'b0, irq);
    @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 chk_word(32'h0000_0000, rdata);
    chk_bit(1'b1, sck_oe_n);
    rd_reg(OFF_STATUS, d);
    chk_word(32'h0000_00F3, d);
    rd_reg(OFF_OPERATE, d);
    chk_word(32'h0000_00BE, d);
  endtask

  // Main sequence.
  initial begin
    reset      = 1'b1;
    ce         = 1'b1;
    addr       = 8'h00;
    wdata      = 32'h0000_0000;
    wr         = 1'b0;
    rd         = 1'b0;
    fail_count = 0;
    checked    = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_mode();
    t_tx_rates();
    t_rx();
    t_ext();
    t_stop_reset();
    wrap_up();
  end
endmodule
